// [common/dtp_pkg.sv]
// Package: register map, field layout and reset values of the down timer
package dtp_pkg;
   // Register indices (printed offsets are not multiples of four)
   localparam logic [2:0] REG_TIMER_COUNT    = 3'h0;
   localparam logic [2:0] REG_TIMER_CTRL_ONE = 3'h1;
   localparam logic [2:0] REG_TIMER_CTRL_TWO = 3'h2;
   localparam logic [2:0] REG_PWM_DUTY       = 3'h3;
   localparam logic [2:0] REG_PRESCALE_VALUE = 3'h4;
   localparam logic [2:0] REG_BUZZER_CTRL    = 3'h5;
   localparam int         NUM_REGS           = 6;
   // Control one fields
   localparam int BIT_TIMER_ENABLE  = 0;
   localparam int BIT_RELOAD_SELECT = 1;
   localparam int BIT_ONE_SHOT      = 2;
   localparam int BIT_PWM_POLARITY  = 6;
   localparam int BIT_PWM_OUT_EN    = 7;
   // Control two fields
   localparam int BIT_PRESCALE_SEL_LO = 0;
   localparam int BIT_PRESCALE_EN_N   = 3;
   localparam int BIT_EDGE_SELECT     = 4;
   localparam int BIT_CLOCK_SOURCE    = 5;
   // Buzzer fields
   localparam int BIT_BUZZER_SEL_LO = 0;
   localparam int BIT_BUZZER_ENABLE = 7;
   // Reset values
   localparam logic [7:0] RST_CTRL_ONE     = 8'h00;
   localparam logic [7:0] RST_CTRL_TWO     = 8'h3f;
   localparam logic [7:0] RST_PRESCALE     = 8'hff;
   localparam logic [7:0] RST_BUZZER       = 8'h0f;
   localparam logic [7:0] RST_COUNT        = 8'hff;
   localparam logic [7:0] RST_DUTY         = 8'h00;
   localparam logic [7:0] COUNT_WRAP_VALUE = 8'hff;
   // Own status register holding the sticky underflow flag
   localparam logic [2:0] REG_STATUS     = 3'h6;
   localparam int         BIT_UNDERFLOW  = 0;
endpackage : dtp_pkg

// [common/dtp_tick_if.sv]
// Interface: timer tick and prescaler taps between the clock front end and core
`timescale 1ns/100ps
`default_nettype none
interface dtp_tick_if;
   logic       tick;       // One-cycle decrement strobe
   logic [7:0] prescaleCnt; // Live prescaler counter
   modport source (output tick, output prescaleCnt);
   modport sink   (input tick, input prescaleCnt);
endinterface : dtp_tick_if
`default_nettype wire

// [design/dtp_apb_regs.sv]
// APB slave decode and ready generation for the down timer
`timescale 1ns/100ps
`default_nettype none
module dtp_apb_regs
   import dtp_pkg::*;
(
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   output logic             pready,
   output logic             pslverr,
   output logic             wrStrobe,
   output logic [2:0]       regIndex,
   output logic             mapped
);
   // Index is byte address over four; low bits must be zero
   assign regIndex = paddr[4:2];
   assign mapped   = (paddr[31:5] == 27'h0) && (paddr[1:0] == 2'h0)
                     && (regIndex <= REG_STATUS);
   // Zero wait state access
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !mapped;
   assign wrStrobe = psel && penable && pwrite && mapped;
endmodule : dtp_apb_regs
`default_nettype wire

// [design/dtp_clock_front.sv]
// Clock source select, edge detect and prescaler of the down timer
`timescale 1ns/100ps
`default_nettype none
module dtp_clock_front
   import dtp_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       instrTick,      // Instruction clock strobe
   input  wire logic       extClockPin,    // External clock level
   input  wire logic       clockSource,
   input  wire logic       edgeSelect,
   input  wire logic       prescaleEnN,
   input  wire logic [2:0] prescaleSel,
   dtp_tick_if.source      tickBus
);
   logic       extPrev_reg;   // Previous external level
   logic       srcTick;       // Selected source event
   logic [7:0] presc_reg;     // Down-running prescaler
   logic [7:0] presc_next;

   // Remember last pin level for edge detection; it tracks the pin
   // through reset too, so a pin resting high gives no false edge
   always_ff @(posedge clk)
   begin
      extPrev_reg <= extClockPin;
   end

   // Source and edge choice
   always_comb
   begin
      if (clockSource)
         srcTick = edgeSelect ? (extPrev_reg & ~extClockPin)
                              : (~extPrev_reg & extClockPin);
      else
         srcTick = instrTick;
   end

   // Prescaler runs down on each source event while enabled
   always_ff @(posedge clk)
   begin
      if (reset)
         presc_reg <= RST_PRESCALE;
      else
         presc_reg <= presc_next;
   end

   assign presc_next = (!prescaleEnN && srcTick) ? presc_reg - 8'h01
                                                  : presc_reg;

   // Tick when the selected bit falls: divide by 2^(sel+1)
   always_comb
   begin
      if (prescaleEnN)
         tickBus.tick = srcTick;
      else
         tickBus.tick = srcTick && presc_reg[prescaleSel]
                        && !presc_next[prescaleSel];
   end

   assign tickBus.prescaleCnt = presc_reg;
endmodule : dtp_clock_front
`default_nettype wire

// [design/dtp_timer_top.sv]
// Top: 8-bit down timer with PWM and buzzer, APB registers
`timescale 1ns/100ps
`default_nettype none
module dtp_timer_top
   import dtp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        instrTick,
   input  wire logic        externalClockPin,
   input  wire logic        gpioOut,
   output logic             sharedOutputPin,
   output logic             buzzerOut,
   output logic             underflowInterruptFlag
);
   logic       wrStrobe;        // Accepted write
   logic [2:0] regIndex;        // Word index
   logic       mapped;          // Address decodes
   logic [7:0] count_reg;       // Running counter
   logic [7:0] reload_reg;      // Hidden reload value
   logic [7:0] ctrlOne_reg;     // Mode and PWM bits
   logic [7:0] ctrlTwo_reg;     // Clock and prescaler bits
   logic [7:0] duty_reg;        // PWM compare
   logic [7:0] buzzer_reg;      // Buzzer select and enable
   logic       stopped_reg;     // One-shot has finished
   logic       pwmActive_reg;   // PWM in active phase
   logic       flag_reg;        // Sticky underflow
   logic       buzz_reg;        // Registered buzzer level
   logic       pinOut_reg;      // Registered pin level
   logic       underflow;       // Counter leaves zero this cycle
   logic       decrement;       // Counter steps this cycle
   logic       timerEnable;
   logic       oneShot;
   logic       reloadSelect;
   logic       buzzSource;
   logic       statusWrite;

   dtp_tick_if tickBus ();

   // Clock source front end
   dtp_clock_front u_front (
      .clk         (clk),
      .reset       (reset),
      .instrTick   (instrTick),
      .extClockPin (externalClockPin),
      .clockSource (ctrlTwo_reg[BIT_CLOCK_SOURCE]),
      .edgeSelect  (ctrlTwo_reg[BIT_EDGE_SELECT]),
      .prescaleEnN (ctrlTwo_reg[BIT_PRESCALE_EN_N]),
      .prescaleSel (ctrlTwo_reg[BIT_PRESCALE_SEL_LO +: 3]),
      .tickBus     (tickBus)
   );

   // Bus decode
   dtp_apb_regs u_bus (
      .psel     (psel),
      .penable  (penable),
      .pwrite   (pwrite),
      .paddr    (paddr),
      .pready   (pready),
      .pslverr  (pslverr),
      .wrStrobe (wrStrobe),
      .regIndex (regIndex),
      .mapped   (mapped)
   );

   assign timerEnable  = ctrlOne_reg[BIT_TIMER_ENABLE];
   assign oneShot      = ctrlOne_reg[BIT_ONE_SHOT];
   assign reloadSelect = ctrlOne_reg[BIT_RELOAD_SELECT];
   // Hold while disabled or after one-shot end
   assign decrement    = timerEnable && !stopped_reg && tickBus.tick;
   // Underflow is the step taken from zero
   assign underflow    = decrement && (count_reg == 8'h00);
   assign statusWrite  = wrStrobe && (regIndex == REG_STATUS);

   // Control registers; rate changes are software's care
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ctrlOne_reg <= RST_CTRL_ONE;
         ctrlTwo_reg <= RST_CTRL_TWO;
         duty_reg    <= RST_DUTY;
         buzzer_reg  <= RST_BUZZER;
      end
      else if (wrStrobe)
      begin
         unique case (regIndex)
            REG_TIMER_CTRL_ONE: ctrlOne_reg <= pwdata[7:0];
            REG_TIMER_CTRL_TWO: ctrlTwo_reg <= pwdata[7:0];
            REG_PWM_DUTY:       duty_reg    <= pwdata[7:0];
            REG_BUZZER_CTRL:    buzzer_reg  <= pwdata[7:0];
            default:            ;
         endcase
      end
   end

   // Counter and reload value
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         count_reg  <= RST_COUNT;
         reload_reg <= RST_COUNT;
      end
      else if (wrStrobe && regIndex == REG_TIMER_COUNT)
      begin
         count_reg  <= pwdata[7:0];
         reload_reg <= pwdata[7:0];
      end
      else if (underflow)
      begin
         if (oneShot)
            count_reg <= 8'h00;
         else if (reloadSelect)
            count_reg <= reload_reg;
         else
            count_reg <= COUNT_WRAP_VALUE;
      end
      else if (decrement)
         count_reg <= count_reg - 8'h01;
   end

   // One-shot stop; a new count write or disable rearms it
   always_ff @(posedge clk)
   begin
      if (reset)
         stopped_reg <= 1'b0;
      else if ((wrStrobe && regIndex == REG_TIMER_COUNT) || !timerEnable)
         stopped_reg <= 1'b0;
      else if (decrement && oneShot && count_reg == 8'h01)
         stopped_reg <= 1'b1;
   end

   // PWM phase: active from duty match to underflow
   always_ff @(posedge clk)
   begin
      if (reset || !timerEnable)
         pwmActive_reg <= 1'b0;
      else if (underflow)
         pwmActive_reg <= 1'b0;
      else if (count_reg == duty_reg)
         pwmActive_reg <= 1'b1;
   end

   // Pin mux with polarity; the gpio path passes when PWM is off
   always_ff @(posedge clk)
   begin
      if (reset)
         pinOut_reg <= 1'b0;
      else if (ctrlOne_reg[BIT_PWM_OUT_EN])
         pinOut_reg <= pwmActive_reg ^ ctrlOne_reg[BIT_PWM_POLARITY];
      else
         pinOut_reg <= gpioOut;
   end
   assign sharedOutputPin = pinOut_reg;

   // Buzzer tap select
   always_comb
   begin
      if (buzzer_reg[BIT_BUZZER_SEL_LO + 3])
         buzzSource = count_reg[buzzer_reg[BIT_BUZZER_SEL_LO +: 3]];
      else
         buzzSource = tickBus.prescaleCnt[buzzer_reg[BIT_BUZZER_SEL_LO +: 3]];
   end

   // Buzzer output held low when off
   always_ff @(posedge clk)
   begin
      if (reset)
         buzz_reg <= 1'b0;
      else
         buzz_reg <= buzzer_reg[BIT_BUZZER_ENABLE] & buzzSource;
   end
   assign buzzerOut = buzz_reg;

   // Sticky flag: set wins over a write-one clear
   always_ff @(posedge clk)
   begin
      if (reset)
         flag_reg <= 1'b0;
      else if (underflow)
         flag_reg <= 1'b1;
      else if (statusWrite && pwdata[BIT_UNDERFLOW])
         flag_reg <= 1'b0;
   end
   assign underflowInterruptFlag = flag_reg;

   // Read mux; write-only registers read as zero
   always_comb
   begin
      prdata = 32'h0;
      if (mapped)
      begin
         unique case (regIndex)
            REG_TIMER_COUNT:    prdata[7:0] = count_reg;
            REG_TIMER_CTRL_ONE: prdata[2:0] = ctrlOne_reg[2:0];
            REG_TIMER_CTRL_TWO: prdata[5:0] = ctrlTwo_reg[5:0];
            REG_PRESCALE_VALUE: prdata[7:0] = tickBus.prescaleCnt;
            REG_STATUS:         prdata[BIT_UNDERFLOW] = flag_reg;
            default:            prdata = 32'h0;
         endcase
      end
   end

   // Assertions, all sampled on the rising clock edge
   // Reload value comes back on underflow
   a_reload_on_under: assert property (
      @(posedge clk) disable iff (reset)
      underflow && !oneShot && reloadSelect && !wrStrobe
      |=> count_reg == $past(reload_reg))
      else $error("reload not taken");
   // Plain continuous mode restarts from the top
   a_wrap_to_ff: assert property (
      @(posedge clk) disable iff (reset)
      underflow && !oneShot && !reloadSelect && !wrStrobe
      |=> count_reg == 8'hff)
      else $error("no wrap to ff");
   // A finished one-shot ignores further ticks
   a_oneshot_stops: assert property (
      @(posedge clk) disable iff (reset)
      stopped_reg && timerEnable && !wrStrobe |=> $stable(count_reg))
      else $error("one-shot moved");
   // A finished one-shot rests at zero
   a_oneshot_zero: assert property (
      @(posedge clk) disable iff (reset)
      stopped_reg |-> count_reg == 8'h00)
      else $error("one-shot not at zero");
   // Count write lands in counter and reload alike
   a_write_loads: assert property (
      @(posedge clk) disable iff (reset)
      wrStrobe && regIndex == REG_TIMER_COUNT
      |=> count_reg == $past(pwdata[7:0]) && reload_reg == count_reg)
      else $error("count write lost");
   // Disabled timer holds its value
   a_hold_disabled: assert property (
      @(posedge clk) disable iff (reset)
      !timerEnable && !wrStrobe |=> $stable(count_reg))
      else $error("counted while disabled");
   // Prescaler off: each instruction tick steps once
   a_direct_step: assert property (
      @(posedge clk) disable iff (reset)
      ctrlTwo_reg[BIT_PRESCALE_EN_N] && !ctrlTwo_reg[BIT_CLOCK_SOURCE]
      && instrTick && timerEnable && !stopped_reg && !wrStrobe
      && count_reg != 8'h00
      |=> count_reg == $past(count_reg) - 8'h01)
      else $error("direct tick missed");
   // External source, rising edge chosen
   a_ext_rise: assert property (
      @(posedge clk) disable iff (reset)
      ctrlTwo_reg[BIT_CLOCK_SOURCE] && !ctrlTwo_reg[BIT_EDGE_SELECT]
      && ctrlTwo_reg[BIT_PRESCALE_EN_N] && $rose(externalClockPin)
      && timerEnable && !stopped_reg && !wrStrobe && count_reg != 8'h00
      |=> count_reg == $past(count_reg) - 8'h01)
      else $error("rising edge not counted");
   // External source, falling edge chosen
   a_ext_fall: assert property (
      @(posedge clk) disable iff (reset)
      ctrlTwo_reg[BIT_CLOCK_SOURCE] && ctrlTwo_reg[BIT_EDGE_SELECT]
      && ctrlTwo_reg[BIT_PRESCALE_EN_N] && $fell(externalClockPin)
      && timerEnable && !stopped_reg && !wrStrobe && count_reg != 8'h00
      |=> count_reg == $past(count_reg) - 8'h01)
      else $error("falling edge not counted");
   // Every underflow raises the flag
   a_flag_sticky: assert property (
      @(posedge clk) disable iff (reset)
      underflow |=> flag_reg)
      else $error("flag not set");
   // Write-one clear works when no underflow competes
   a_flag_clear: assert property (
      @(posedge clk) disable iff (reset)
      statusWrite && pwdata[BIT_UNDERFLOW] && !underflow |=> !flag_reg)
      else $error("flag not cleared");
   // Buzzer off means a low output
   a_buzz_off_low: assert property (
      @(posedge clk) disable iff (reset)
      !buzzer_reg[BIT_BUZZER_ENABLE] |=> !buzzerOut)
      else $error("buzzer on while off");
   // Upper codes follow a counter bit
   a_buzz_count_bit: assert property (
      @(posedge clk) disable iff (reset)
      buzzer_reg[BIT_BUZZER_ENABLE] && buzzer_reg[BIT_BUZZER_SEL_LO + 3]
      |=> buzzerOut == $past(count_reg[buzzer_reg[BIT_BUZZER_SEL_LO +: 3]]))
      else $error("buzzer count tap wrong");
   // Lower codes follow a prescaler bit
   a_buzz_prescale: assert property (
      @(posedge clk) disable iff (reset)
      buzzer_reg[BIT_BUZZER_ENABLE] && !buzzer_reg[BIT_BUZZER_SEL_LO + 3]
      |=> buzzerOut
          == $past(tickBus.prescaleCnt[buzzer_reg[BIT_BUZZER_SEL_LO +: 3]]))
      else $error("buzzer prescaler tap wrong");
   // Duty match opens the active phase
   a_pwm_set_match: assert property (
      @(posedge clk) disable iff (reset)
      timerEnable && !underflow && count_reg == duty_reg |=> pwmActive_reg)
      else $error("pwm not active at match");
   // Underflow closes the active phase
   a_pwm_clear_under: assert property (
      @(posedge clk) disable iff (reset)
      underflow |=> !pwmActive_reg)
      else $error("pwm active after underflow");
   // Pin shows the phase through the polarity seen one cycle before
   a_pwm_pin_level: assert property (
      @(posedge clk) disable iff (reset)
      ctrlOne_reg[BIT_PWM_OUT_EN]
      |=> sharedOutputPin == ($past(pwmActive_reg)
                              ^ $past(ctrlOne_reg[BIT_PWM_POLARITY])))
      else $error("pwm pin wrong");
   // PWM output off leaves the pin to the gpio level
   a_gpio_passes: assert property (
      @(posedge clk) disable iff (reset)
      !ctrlOne_reg[BIT_PWM_OUT_EN] |=> sharedOutputPin == $past(gpioOut))
      else $error("gpio level lost");
   // Count reads see the live counter
   a_count_read: assert property (
      @(posedge clk) disable iff (reset)
      psel && !pwrite && mapped && regIndex == REG_TIMER_COUNT
      |-> prdata[7:0] == count_reg)
      else $error("count read wrong");
   // Main scenarios worth seeing at least once
   c_underflow:  cover property (@(posedge clk) disable iff (reset) underflow);
   c_pwm_active: cover property (@(posedge clk) disable iff (reset)
      $rose(pwmActive_reg));
   c_stop:       cover property (@(posedge clk) disable iff (reset)
      $rose(stopped_reg));
   c_wrap_ff:    cover property (@(posedge clk) disable iff (reset)
      underflow && !oneShot && !reloadSelect);
   c_buzz_on:    cover property (@(posedge clk) disable iff (reset)
      $rose(buzzerOut));
endmodule : dtp_timer_top
`default_nettype wire

// [verification/down_timer_pwm_buzzer_tb.sv]
// Self-checking testbench of the down timer with PWM and buzzer
`timescale 1ns/100ps
`default_nettype none
module down_timer_pwm_buzzer_tb
   import dtp_pkg::*;
;
   logic        clk, reset, psel, penable, pwrite;  // Clock, reset, APB
   logic [31:0] paddr, pwdata, prdata;              // APB address and data
   logic        pready, pslverr;                    // APB answer
   logic        instrTick, extPin, gpioOut;         // Timer side inputs
   logic        pinOut, buzzOut, flagOut;           // Observed outputs
   logic [31:0] rdat;                               // Last read word
   logic        rerr;                               // Last error bit
   logic [7:0]  v, ps;                              // Random count, prescaler
   int          fail_count, samples_checked, k, n;  // Counters

   dtp_timer_top uut (.clk(clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .instrTick(instrTick), .externalClockPin(extPin), .gpioOut(gpioOut),
      .sharedOutputPin(pinOut), .buzzerOut(buzzOut),
      .underflowInterruptFlag(flagOut));

   // Free running 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Verdict and end of run
   task close_out();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : close_out

   // Compare one value, counted either way
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One APB transfer; request held until pready is seen high
   task apb(input logic wr, input logic [2:0] idx, input logic [7:0] d);
      int t;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {27'h0, idx, 2'b00};   // Word index times four
      pwdata  <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      t = 0;
      do
      begin
         @(posedge clk);
         t++;
      end while (pready !== 1'b1 && t < 50);
      // Bounded wait: a dead slave ends the run
      if (pready !== 1'b1)
      begin
         fail_count++;
         close_out();
      end
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);   // Keeps two requests out of one time step
   endtask : apb

   // Read a register and compare the whole read word
   task rd(input logic [2:0] idx, input logic [31:0] exp, input string what);
      apb(1'b0, idx, 8'h00);
      chk(what, exp, rdat);
   endtask : rd

   // Instruction ticks, spaced so registered outputs have settled
   task tick(input int cnt);
      repeat (cnt)
      begin
         instrTick <= 1'b1;
         @(posedge clk);
         instrTick <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask : tick

   // Toggle the external pin; counts the edges of the chosen kind
   task ext(input int cnt, input logic fall, output int hits);
      hits = 0;
      repeat (cnt)
      begin
         if (extPin == fall)
            hits++;
         extPin <= ~extPin;
         repeat (4) @(posedge clk);
      end
   endtask : ext

   // Decrement strobes given by the prescaler tap after cnt events
   function automatic int preTicks(input int sel, input int cnt);
      int c;
      logic [7:0] p, q;
      c = 0;
      p = 8'hff;
      for (int i = 0; i < cnt; i++)
      begin
         q = p - 8'h01;
         if (p[sel] && !q[sel])
            c++;
         p = q;
      end
      return c;
   endfunction : preTicks

   // Main sequence
   initial
   begin
      {reset, psel, penable, pwrite, instrTick, extPin} = 6'b100000;
      {paddr, pwdata} = '0;
      gpioOut = 1'b0;
      fail_count = 0;
      samples_checked = 0;
      void'($urandom(59081));
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      // Reset values, write-only reads and an unmapped word
      rd(REG_TIMER_CTRL_ONE, 32'h00, "ctrl one");
      rd(REG_TIMER_CTRL_TWO, 32'h3f, "ctrl two");
      rd(REG_PRESCALE_VALUE, 32'hff, "prescaler");
      rd(REG_PWM_DUTY, 32'h00, "duty");
      rd(REG_BUZZER_CTRL, 32'h00, "buzzer");
      apb(1'b0, 3'h7, 8'h00);
      chk("slverr", 32'h1, {31'h0, rerr});
      $display("test reset done");
      // Prescaler: rate set while off, then switched on
      k = $urandom % 8;
      n = (4 << k) + $urandom % 3;
      v = 8'h10 + 8'($urandom % 16);
      apb(1'b1, REG_TIMER_CTRL_TWO, 8'h08 | 8'(k));
      apb(1'b1, REG_TIMER_CTRL_TWO, 8'(k));
      apb(1'b1, REG_TIMER_COUNT, v);
      apb(1'b1, REG_TIMER_CTRL_ONE, 8'h01);
      tick(n);
      rd(REG_TIMER_COUNT, 32'(v - 8'(preTicks(k, n))), "count");
      rd(REG_PRESCALE_VALUE, 32'(8'hff - 8'(n)), "prescaler");
      apb(1'b1, REG_TIMER_CTRL_TWO, 8'h08 | 8'(k));
      apb(1'b1, REG_TIMER_CTRL_TWO, 8'h08);
      $display("test prescaler done");
      // Wrap, reload, one-shot with either reload bit, from count 2
      for (int m = 0; m < 4; m++)
      begin
         v = 8'($urandom);
         apb(1'b1, REG_TIMER_CTRL_ONE, 8'h00);
         apb(1'b1, REG_TIMER_COUNT, v);
         tick(2);
         rd(REG_TIMER_COUNT, {24'h0, v}, "held");
         apb(1'b1, REG_STATUS, 8'h01);
         chk("flag clr", 32'h0, {31'h0, flagOut});
         apb(1'b1, REG_TIMER_COUNT, 8'h02);
         apb(1'b1, REG_TIMER_CTRL_ONE, 8'h01 | 8'(m << 1));
         tick(4);
         rd(REG_TIMER_COUNT, m == 0 ? 32'hfe : m == 1 ? 32'h1 : 32'h0,
            "mode");
         chk("flag", {31'h0, m < 2}, {31'h0, flagOut});
         rd(REG_STATUS, {31'h0, m < 2}, "status");
      end
      $display("test modes done");
      // External pin, both edges; instruction ticks ignored there
      apb(1'b1, REG_TIMER_COUNT, 8'h40);
      v = 8'h40;
      for (int e = 0; e < 2; e++)
      begin
         apb(1'b1, REG_TIMER_CTRL_TWO, e ? 8'h38 : 8'h28);
         apb(1'b1, REG_TIMER_CTRL_ONE, 8'h01);
         ext(5, e[0], n);
         tick(2);
         v = v - 8'(n);
         rd(REG_TIMER_COUNT, {24'h0, v}, "ext count");
         apb(1'b1, REG_TIMER_CTRL_ONE, 8'h00);
      end
      apb(1'b1, REG_TIMER_CTRL_TWO, 8'h08);
      $display("test external done");
      // PWM reload 4 (five-tick frame), duty 2, both polarities, pin sharing
      for (int p = 0; p < 2; p++)
      begin
         apb(1'b1, REG_TIMER_COUNT, 8'h04);
         apb(1'b1, REG_PWM_DUTY, 8'h02);
         gpioOut <= 1'($urandom);
         apb(1'b1, REG_TIMER_CTRL_ONE, 8'h03 | 8'(p << 6));
         chk("gpio pin", {31'h0, gpioOut}, {31'h0, pinOut});
         apb(1'b1, REG_TIMER_CTRL_ONE, 8'h83 | 8'(p << 6));
         tick(5);   // First frame clears any stale active state
         for (int s = 1; s <= 5; s++)
         begin
            tick(1);
            chk("pwm pin", {31'h0, (s >= 2 && s <= 4) ^ p[0]},
               {31'h0, pinOut});
         end
      end
      $display("test pwm done");
      // Buzzer: every code on, then off, with the timer frozen
      apb(1'b1, REG_TIMER_CTRL_ONE, 8'h00);
      v = 8'($urandom);
      apb(1'b1, REG_TIMER_COUNT, v);
      apb(1'b0, REG_PRESCALE_VALUE, 8'h00);
      ps = rdat[7:0];
      for (int c = 0; c < 16; c++)
      begin
         apb(1'b1, REG_BUZZER_CTRL, 8'h80 | 8'(c));
         repeat (2) @(posedge clk);
         chk("buzzer", {31'h0, c < 8 ? ps[c % 8] : v[c % 8]},
            {31'h0, buzzOut});
         apb(1'b1, REG_BUZZER_CTRL, 8'(c));
         repeat (2) @(posedge clk);
         chk("buzzer off", 32'h0, {31'h0, buzzOut});
      end
      $display("test buzzer done");
      close_out();
   end
endmodule : down_timer_pwm_buzzer_tb
`default_nettype wire
